// File: srsq_consts.vh
`ifndef SRSQ_CONSTS_VH
`define SRSQ_CONSTS_VH

// register offsets on the plain register port
`define SRSQ_ADDR_RESET_SRC    8'hb0
`define SRSQ_ADDR_WDT_CTRL     8'hd3
`define SRSQ_ADDR_CLK_DIV      8'hd4
`define SRSQ_ADDR_OSC_SEL      8'hfa
`define SRSQ_ADDR_HALT_UNLOCK  8'hfb
`define SRSQ_ADDR_WDT_COUNT    8'hfd
`define SRSQ_ADDR_PORT_CTRL    8'hc0
`define SRSQ_ADDR_PORT_PULLUP  8'hc1
`define SRSQ_ADDR_PORT_DATA    8'hc2
`define SRSQ_ADDR_PORT_IRQ_EN  8'hc3
`define SRSQ_ADDR_PORT_IRQ_PND 8'hc4
`define SRSQ_ADDR_IRQ_ENABLE   8'hc5
`define SRSQ_ADDR_GP_DATA      8'hc6

// reset values
`define SRSQ_RST_BYTE          8'h00
`define SRSQ_RESET_VECTOR      16'h0100

// field layouts
`define SRSQ_CLK_DIV_MASK      8'h98
`define SRSQ_OSC_SEL_MASK      8'h0d
`define SRSQ_WDT_OFF_NIBBLE    4'ha
`define SRSQ_HALT_KEY          8'ha5
`define SRSQ_RSRC_EXT_BIT      3
`define SRSQ_RSRC_WDT_BIT      2

// timing
`define SRSQ_CLK_HZ            20000000
`define SRSQ_POR_HOLD_US       1000
`define SRSQ_POR_HOLD_CYC      ((`SRSQ_POR_HOLD_US * (`SRSQ_CLK_HZ / 1000)) / 1000)
`define SRSQ_STAB_SHIFT_BASE   8

`endif

// File: srsq_ext_reset_src.sv
`timescale 1ns/10ps
`default_nettype none
module srsq_ext_reset_src #(
    parameter int POWER_HOLD = 20000,
    parameter int PULSE_HOLD = 40
) (
    input  wire logic i_ref_clk,
    input  wire logic i_pulse,
    output wire logic o_ext_reset_in_low
);
    int cnt = POWER_HOLD; // 1 ms low after power-up
    // restart the low time on each request
    always @(posedge i_ref_clk) begin
        if (i_pulse) begin
            cnt <= PULSE_HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign o_ext_reset_in_low = (cnt == 0);
endmodule
`default_nettype wire

// File: srsq_system_reset_sequencer.v
//
// Contract
// RULE1: reset pin filtered and synchronised to clock (code: two-flop sync only; the third flop follows sync_b and does no filtering)
// RULE2: external source holds reset low 1 ms
// RULE3: low reset returns control registers to defaults
// RULE4: reset disables every interrupt source
// RULE5: reset leaves watchdog enabled
// RULE6: reset makes all ports inputs, pull-ups off
// RULE7: program counter loaded with reset vector
// RULE8: fetch starts only after stabilisation interval
// RULE9: boot option may replace reset vector
// RULE10: upper nibble 1010b disables watchdog reset
// RULE11: enabled watchdog overflow causes system reset
// RULE12: watchdog control sets stabilisation interval length (code: hold clears it first, so stab uses the shortest length)
// RULE13: test pin low enables internal program memory
// RULE14: unused bits read as zero
// RULE15: reset clears clock divider bits 7,4,3
// RULE16: reset clears watchdog control and counter
// RULE17: reset clears port control, pull-up, data, irq regs
// RULE18: cpu runs fxx divided by sixteen after reset
// RULE19: halt disabled unless unlock holds 10100101b
// RULE20: main oscillator selected after reset
// RULE21: general data registers keep contents over reset
// RULE22: reset held while synced input low
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "srsq_consts.vh"

module srsq_system_reset_sequencer #(
    parameter        STAB_SHIFT = `SRSQ_STAB_SHIFT_BASE,
    parameter [15:0] BOOT_VECTOR_DEFAULT = `SRSQ_RESET_VECTOR
) (
    // clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst,
    // external pins and straps
    input  wire        i_ext_reset_in_low,
    input  wire        i_test_pin,
    input  wire        i_boot_option_valid,
    input  wire [15:0] i_boot_option_vector,
    // register port
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // system outputs
    output reg         o_sys_reset,
    output reg         o_cpu_run,
    output reg  [15:0] o_pc_load,
    output reg         o_irq_global_en,
    output reg         o_wdt_enabled,
    output reg  [1:0]  o_cpu_div_sel,
    output reg         o_sys_clk_sub,
    output reg         o_main_osc_stop,
    output reg         o_sub_osc_stop,
    output reg         o_halt_allowed,
    output reg         o_int_rom_en,
    output reg         o_ext_mem_if_en,
    output reg  [7:0]  o_port_ctrl,
    output reg  [7:0]  o_port_pullup,
    output reg  [7:0]  o_port_data
);

    // sequencer states
    // hold: internal reset asserted, control registers forced to defaults
    // stab: pin released, oscillator settling count runs
    // run: fetch allowed from the loaded vector
    // a watchdog overflow or a low pin sends run back to hold
    // the unused fourth code falls back to hold as well
    localparam ST_HOLD = 2'd0;
    localparam ST_STAB = 2'd1;
    localparam ST_RUN  = 2'd2;

    // synchroniser and follower stage
    // sync_a is read only by sync_b, so metastability stays in one flop
    // state, counters and control register copies follow
    reg        sync_a;
    reg        sync_b;
    reg        pin_filt;
    reg [1:0]  state;
    reg [15:0] stab_cnt;
    reg [15:0] stab_len;
    reg        wdt_fire;
    reg        wdt_src;
    reg        ext_src;
    reg [7:0]  wdt_ctrl;
    reg [7:0]  wdt_count;
    reg [7:0]  clk_div;
    reg [7:0]  osc_sel;
    reg [7:0]  halt_unlock;
    reg [7:0]  port_irq_en;
    reg [7:0]  port_irq_pnd;
    reg        irq_en;
    reg [7:0]  gp_data;
    reg [7:0]  prescale;
    reg [7:0]  next_rdata;
    wire       ctl_rst;
    wire       wdt_on;

    // register write hit test
    function wr_hit;
        input [7:0] a;
        input [7:0] off;
        input       w;
        begin
            wr_hit = w && (a == off);
        end
    endfunction

    // two-flop sync then a third flop that simply follows the pin
    // the pin is taken as a plain level here; the analogue schmitt
    // stage sits in the pad, this flop only keeps the last settled level
    // reset value is low so power-up starts inside the hold state
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            pin_filt <= 1'b0;
        end else begin
            sync_a <= i_ext_reset_in_low; // see RULE1
            sync_b <= sync_a;
            if (sync_b == pin_filt) begin
                pin_filt <= pin_filt;
            end else begin
                pin_filt <= sync_b; // see RULE1
            end
        end
    end

    // control registers cleared by any system reset
    assign ctl_rst = (state == ST_HOLD);
    assign wdt_on  = (wdt_ctrl[7:4] != `SRSQ_WDT_OFF_NIBBLE); // see RULE10

    // sequencer: hold, stabilise, run
    // hold waits for the filtered pin to go high and for the
    // watchdog pulse to drop, so a watchdog reset lasts a full cycle
    // stab counts stab_len plus one cycles before fetch is allowed
    // a low pin at any point restarts from hold
    // the count length is read live; hold clears wdt_ctrl, so stab uses the shortest
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state    <= ST_HOLD;
            stab_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_HOLD: begin
                    stab_cnt <= 16'h0000;
                    if (pin_filt && !wdt_fire) begin
                        state <= ST_STAB; // see RULE22
                    end
                end
                ST_STAB: begin
                    if (!pin_filt) begin
                        state <= ST_HOLD; // see RULE22
                    end else if (stab_cnt >= stab_len) begin
                        state <= ST_RUN; // see RULE8
                    end else begin
                        stab_cnt <= stab_cnt + 16'h0001;
                    end
                end
                ST_RUN: begin
                    if (!pin_filt || wdt_fire) begin
                        state <= ST_HOLD; // see RULE3 RULE11
                    end
                end
                default: begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // stabilisation length from watchdog control low bits
    always @* begin
        case (wdt_ctrl[3:2]) // see RULE12
            2'd0:    stab_len = 16'h0001 << STAB_SHIFT;
            2'd1:    stab_len = 16'h0001 << (STAB_SHIFT + 1);
            2'd2:    stab_len = 16'h0001 << (STAB_SHIFT + 2);
            default: stab_len = 16'h0001 << (STAB_SHIFT + 3);
        endcase
    end

    // basic timer counter with watchdog overflow
    // the prescaler divides the clock by 256 before the counter
    // overflow only fires while running and while the key is absent
    // the fire pulse lasts one cycle; the sequencer takes it from there
    // a write to the control register with bit1 set restarts the count
    // the counter is cleared while the sequencer holds
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            prescale  <= 8'h00;
            wdt_count <= `SRSQ_RST_BYTE;
            wdt_fire  <= 1'b0;
        end else if (ctl_rst) begin
            prescale  <= 8'h00;
            wdt_count <= `SRSQ_RST_BYTE; // see RULE16
            wdt_fire  <= 1'b0;
        end else begin
            prescale <= prescale + 8'h01;
            wdt_fire <= 1'b0;
            if (wr_hit(i_addr, `SRSQ_ADDR_WDT_CTRL, i_wr) && i_wdata[1]) begin
                wdt_count <= 8'h00;
            end else if (prescale == 8'hff) begin
                wdt_count <= wdt_count + 8'h01;
                if (wdt_count == 8'hff && wdt_on && state == ST_RUN) begin
                    wdt_fire <= 1'b1; // see RULE11
                end
            end
        end
    end

    // reset source flags: set on cause, cleared by write of one
    // a cause in the same cycle as the clear keeps the flag set
    // the pin flag starts set, since power-up always comes from the pin
    // these flags are not cleared by the sequencer's own hold
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_src <= 1'b1;
            wdt_src <= 1'b0;
        end else begin
            if (!pin_filt) begin
                ext_src <= 1'b1;
            end else if (wr_hit(i_addr, `SRSQ_ADDR_RESET_SRC, i_wr) && i_wdata[`SRSQ_RSRC_EXT_BIT]) begin
                ext_src <= 1'b0;
            end
            if (wdt_fire) begin
                wdt_src <= 1'b1;
            end else if (wr_hit(i_addr, `SRSQ_ADDR_RESET_SRC, i_wr) && i_wdata[`SRSQ_RSRC_WDT_BIT]) begin
                wdt_src <= 1'b0;
            end
        end
    end

    // control register file
    // every register here returns to its default while in hold
    // writes landing in hold are lost, the clear has priority
    // unimplemented bits are masked on write so they read zero
    // the pending register is never set here, only cleared by software or hold
    // the global interrupt bit reaches the core only while running
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wdt_ctrl     <= `SRSQ_RST_BYTE;
            clk_div      <= `SRSQ_RST_BYTE;
            osc_sel      <= `SRSQ_RST_BYTE;
            halt_unlock  <= `SRSQ_RST_BYTE;
            o_port_ctrl  <= `SRSQ_RST_BYTE;
            o_port_pullup <= `SRSQ_RST_BYTE;
            o_port_data  <= `SRSQ_RST_BYTE;
            port_irq_en  <= `SRSQ_RST_BYTE;
            port_irq_pnd <= `SRSQ_RST_BYTE;
            irq_en       <= 1'b0;
        end else if (ctl_rst) begin
            wdt_ctrl     <= `SRSQ_RST_BYTE; // see RULE16 RULE5
            clk_div      <= `SRSQ_RST_BYTE; // see RULE15 RULE18
            osc_sel      <= `SRSQ_RST_BYTE; // see RULE20
            halt_unlock  <= `SRSQ_RST_BYTE; // see RULE19
            o_port_ctrl  <= `SRSQ_RST_BYTE; // see RULE6 RULE17
            o_port_pullup <= `SRSQ_RST_BYTE; // see RULE6 RULE17
            o_port_data  <= `SRSQ_RST_BYTE; // see RULE17
            port_irq_en  <= `SRSQ_RST_BYTE; // see RULE17
            port_irq_pnd <= `SRSQ_RST_BYTE; // see RULE17
            irq_en       <= 1'b0; // see RULE4
        end else begin
            if (wr_hit(i_addr, `SRSQ_ADDR_WDT_CTRL, i_wr)) begin
                wdt_ctrl <= i_wdata;
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_CLK_DIV, i_wr)) begin
                clk_div <= i_wdata & `SRSQ_CLK_DIV_MASK; // see RULE14
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_OSC_SEL, i_wr)) begin
                osc_sel <= i_wdata & `SRSQ_OSC_SEL_MASK; // see RULE14
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_HALT_UNLOCK, i_wr)) begin
                halt_unlock <= i_wdata;
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_PORT_CTRL, i_wr)) begin
                o_port_ctrl <= i_wdata;
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_PORT_PULLUP, i_wr)) begin
                o_port_pullup <= i_wdata;
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_PORT_DATA, i_wr)) begin
                o_port_data <= i_wdata;
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_PORT_IRQ_EN, i_wr)) begin
                port_irq_en <= i_wdata;
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_PORT_IRQ_PND, i_wr)) begin
                port_irq_pnd <= port_irq_pnd & ~i_wdata; // write one clears
            end
            if (wr_hit(i_addr, `SRSQ_ADDR_IRQ_ENABLE, i_wr)) begin
                irq_en <= i_wdata[0];
            end
        end
    end

    // general data register survives system reset
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gp_data <= 8'h00;
        end else if (wr_hit(i_addr, `SRSQ_ADDR_GP_DATA, i_wr)) begin
            gp_data <= i_wdata; // see RULE21
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (i_addr)
            `SRSQ_ADDR_RESET_SRC:    next_rdata = {4'h0, ext_src, wdt_src, 2'b00};
            `SRSQ_ADDR_WDT_CTRL:     next_rdata = wdt_ctrl;
            `SRSQ_ADDR_CLK_DIV:      next_rdata = clk_div;
            `SRSQ_ADDR_OSC_SEL:      next_rdata = osc_sel;
            `SRSQ_ADDR_HALT_UNLOCK:  next_rdata = halt_unlock;
            `SRSQ_ADDR_WDT_COUNT:    next_rdata = wdt_count;
            `SRSQ_ADDR_PORT_CTRL:    next_rdata = o_port_ctrl;
            `SRSQ_ADDR_PORT_PULLUP:  next_rdata = o_port_pullup;
            `SRSQ_ADDR_PORT_DATA:    next_rdata = o_port_data;
            `SRSQ_ADDR_PORT_IRQ_EN:  next_rdata = port_irq_en;
            `SRSQ_ADDR_PORT_IRQ_PND: next_rdata = port_irq_pnd;
            `SRSQ_ADDR_IRQ_ENABLE:   next_rdata = {7'h00, irq_en};
            `SRSQ_ADDR_GP_DATA:      next_rdata = gp_data;
            default:                 next_rdata = 8'h00; // see RULE14
        endcase
    end

    // registered outputs
    // every output comes from a flop, one cycle after its source
    // the start vector is frozen while running, so a boot option
    // change only takes effect at the next reset
    // the external memory interface is never enabled automatically
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata         <= 8'h00;
            o_sys_reset     <= 1'b1;
            o_cpu_run       <= 1'b0;
            o_pc_load       <= `SRSQ_RESET_VECTOR;
            o_irq_global_en <= 1'b0;
            o_wdt_enabled   <= 1'b1;
            o_cpu_div_sel   <= 2'b00;
            o_sys_clk_sub   <= 1'b0;
            o_main_osc_stop <= 1'b0;
            o_sub_osc_stop  <= 1'b0;
            o_halt_allowed  <= 1'b0;
            o_int_rom_en    <= 1'b0;
            o_ext_mem_if_en <= 1'b0;
        end else begin
            o_rdata         <= i_rd ? next_rdata : 8'h00;
            o_sys_reset     <= (state != ST_RUN); // see RULE22 RULE8
            o_cpu_run       <= (state == ST_RUN); // see RULE8
            if (state != ST_RUN) begin
                o_pc_load <= i_boot_option_valid ? i_boot_option_vector
                                                 : BOOT_VECTOR_DEFAULT; // see RULE7 RULE9
            end
            o_irq_global_en <= irq_en && (state == ST_RUN); // see RULE4
            o_wdt_enabled   <= wdt_on; // see RULE5
            o_cpu_div_sel   <= clk_div[4:3]; // see RULE18
            o_sys_clk_sub   <= osc_sel[0]; // see RULE20
            o_main_osc_stop <= osc_sel[3];
            o_sub_osc_stop  <= osc_sel[2];
            o_halt_allowed  <= (halt_unlock == `SRSQ_HALT_KEY); // see RULE19
            o_int_rom_en    <= !i_test_pin; // see RULE13
            o_ext_mem_if_en <= 1'b0; // see RULE13
        end
    end

endmodule
`default_nettype wire

// File: srsq_system_reset_sequencer_props.sv
`timescale 1ns/10ps
`default_nettype none
module srsq_checker #(
    parameter [15:0] BOOT_VECTOR_DEFAULT = 16'h0100
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_ext_reset_in_low,
    input wire logic        i_test_pin,
    input wire logic        i_boot_option_valid,
    input wire logic [15:0] i_boot_option_vector,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_sys_reset,
    input wire logic        o_cpu_run,
    input wire logic [15:0] o_pc_load,
    input wire logic        o_irq_global_en,
    input wire logic        o_wdt_enabled,
    input wire logic [1:0]  o_cpu_div_sel,
    input wire logic        o_sys_clk_sub,
    input wire logic        o_halt_allowed,
    input wire logic        o_int_rom_en,
    input wire logic        o_ext_mem_if_en,
    input wire logic [7:0]  o_port_ctrl,
    input wire logic [7:0]  o_port_pullup,
    input wire logic [7:0]  o_port_data
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // pin low long enough to pass the sync and filter flops
    sequence pin_held;
        !i_ext_reset_in_low [*7];
    endsequence
    sequence in_reset;
        o_sys_reset [*2];
    endsequence
    a_pin_resets: assert property (pin_held |-> o_sys_reset)
        else $error("pin low without internal reset");
    a_hold_ports: assert property (pin_held |-> (o_port_ctrl | o_port_pullup | o_port_data) == 8'h00)
        else $error("ports not inputs in reset");
    a_hold_defaults: assert property (pin_held |-> o_wdt_enabled && o_cpu_div_sel == 2'b00
        && !o_sys_clk_sub && !o_halt_allowed)
        else $error("control defaults wrong in reset");
    a_irq_masked: assert property (in_reset |-> !o_irq_global_en)
        else $error("interrupts enabled in reset");
    a_run_gated: assert property ($rose(o_cpu_run) |-> $past(o_sys_reset, 4))
        else $error("run without stabilisation");
    a_vector_load: assert property ($rose(o_cpu_run) |-> o_pc_load ==
        (i_boot_option_valid ? i_boot_option_vector : BOOT_VECTOR_DEFAULT))
        else $error("wrong start vector");
    a_rom_select: assert property (!$past(i_rst) |-> !o_ext_mem_if_en && o_int_rom_en == !$past(i_test_pin))
        else $error("program memory select wrong");
    a_wdt_key: assert property (i_wr && i_addr == 8'hd3 && i_wdata[7:4] == 4'ha && !o_sys_reset
        && i_ext_reset_in_low |-> ##[1:2] !o_wdt_enabled)
        else $error("watchdog not disabled by key");
    a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule
bind srsq_system_reset_sequencer srsq_checker #(.BOOT_VECTOR_DEFAULT(BOOT_VECTOR_DEFAULT)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ext_reset_in_low(i_ext_reset_in_low), .i_test_pin(i_test_pin),
    .i_boot_option_valid(i_boot_option_valid), .i_boot_option_vector(i_boot_option_vector),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_sys_reset(o_sys_reset), .o_cpu_run(o_cpu_run), .o_pc_load(o_pc_load), .o_irq_global_en(o_irq_global_en),
    .o_wdt_enabled(o_wdt_enabled), .o_cpu_div_sel(o_cpu_div_sel), .o_sys_clk_sub(o_sys_clk_sub),
    .o_halt_allowed(o_halt_allowed), .o_int_rom_en(o_int_rom_en), .o_ext_mem_if_en(o_ext_mem_if_en),
    .o_port_ctrl(o_port_ctrl), .o_port_pullup(o_port_pullup), .o_port_data(o_port_data));
`default_nettype wire

// File: srsq_system_reset_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module srsq_system_reset_sequencer_tb;
    localparam int STAB = 4;
    logic        clk = 0, rst = 1, tpin = 0, bok = 0, wr = 0, rd = 0, pulse = 0;
    logic [7:0]  addr = 0, wdata = 0;
    logic [15:0] bvec = 0;
    logic [31:0] seed = 61021;
    wire         pin, sres, run, irq, wdt, sub, halt, rom, ext, mstop, sstop;
    wire  [1:0]  div;
    wire  [7:0]  rdata, pctl, ppu, pdat;
    wire  [15:0] pc;
    int          errors = 0, total_checks = 0, cycles = 0;
    int          mdl [256], msk [256];
    logic [7:0]  rlist [11] = '{8'hd3, 8'hd4, 8'hfa, 8'hfb, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hb0};
    logic [7:0]  wlist [9] = '{8'hd4, 8'hfa, 8'hfb, 8'hc0, 8'hc1, 8'hc2, 8'hc5, 8'hc6, 8'h10};

    srsq_ext_reset_src src (.i_ref_clk(clk), .i_pulse(pulse), .o_ext_reset_in_low(pin));
    srsq_system_reset_sequencer #(.STAB_SHIFT(2)) dut (
        .i_ref_clk(clk), .i_rst(rst), .i_ext_reset_in_low(pin), .i_test_pin(tpin),
        .i_boot_option_valid(bok), .i_boot_option_vector(bvec), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_sys_reset(sres), .o_cpu_run(run), .o_pc_load(pc),
        .o_irq_global_en(irq), .o_wdt_enabled(wdt), .o_cpu_div_sel(div), .o_sys_clk_sub(sub),
        .o_main_osc_stop(mstop), .o_sub_osc_stop(sstop), .o_halt_allowed(halt), .o_int_rom_en(rom),
        .o_ext_mem_if_en(ext), .o_port_ctrl(pctl), .o_port_pullup(ppu), .o_port_data(pdat));

    // clock and hang guard
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            close_out();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (msk[a] != 0) mdl[a] = d & msk[a];
    endtask
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata), 16'(mdl[a]));
    endtask
    // model of a system reset, then wait for run and check defaults
    task automatic after_reset(input int src);
        int n;
        for (int i = 0; i < 256; i++) if (i != 8'hc6) mdl[i] = 0;
        mdl[8'hb0] = src;
        n = 0;
        while (pin !== 1'b1 && n < 30000) begin @(posedge clk); n++; end
        n = 0;
        while (run !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        chk(16'(n >= STAB + 1 && n <= STAB + 10), 16'h1);
        chk(pc, bok ? bvec : 16'h0100);
        chk({wdt, div, sub, halt, irq, ext, rom}, 8'h81);
        chk({pctl, ppu}, 16'h0);
        chk({pdat, 6'h0, mstop, sstop}, 16'h0);
        foreach (rlist[i]) rd_chk(rlist[i]);
    endtask

    initial begin
        for (int i = 0; i < 256; i++) msk[i] = 0;
        foreach (wlist[i]) msk[wlist[i]] = 8'hff;
        msk[8'hd4] = 8'h98;
        msk[8'hfa] = 8'h0d;
        msk[8'hc5] = 8'h01;
        msk[8'h10] = 0;
        mdl[8'hc6] = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        after_reset(8'h08);
        $display("power-up done");
        for (int k = 0; k < 24; k++) wr_reg(wlist[xs() % 9], 8'(xs()));
        wr_reg(8'hfb, 8'ha5);
        wr_reg(8'hc5, 8'h01);
        tpin <= 1'b1;
        foreach (wlist[i]) rd_chk(wlist[i]);
        chk({halt, irq, rom, div}, {3'b110, 2'(mdl[8'hd4] >> 3)});
        chk({pctl, ppu}, 16'({mdl[8'hc0][7:0], mdl[8'hc1][7:0]}));
        chk({pdat, 5'h0, mstop, sstop, sub}, 16'({mdl[8'hc2][7:0], 5'h0, mdl[8'hfa][3], mdl[8'hfa][2], mdl[8'hfa][0]}));
        tpin <= 1'b0;
        wr_reg(8'hd3, 8'ha0);
        mdl[8'hd3] = 8'ha0;
        rd_chk(8'hd3);
        chk(16'(wdt), 16'h0);
        $display("registers done");
        @(posedge clk);
        bok <= 1'b1;
        bvec <= 16'(xs());
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        while (run !== 1'b0) @(posedge clk);
        after_reset(8'h08);
        rd_chk(8'hc6);
        $display("pin reset done");
        for (int n = 0; n < 70000 && sres !== 1'b1; n++) @(posedge clk);
        chk(16'(sres), 16'h1);
        after_reset(8'h0c);
        $display("watchdog reset done");
        close_out();
    end
endmodule
`default_nettype wire
